/* shared/ptc_pkg.sv */
// Package for the privilege and trace control block.
// Assumes a 32-bit AXI4-Lite register bus and one core clock.
package ptc_pkg;
  // Register byte offsets
  localparam logic [7:0] PTC_IP_OFF = 8'h00;
  localparam logic [7:0] PTC_AC_OFF = 8'h04;
  localparam logic [7:0] PTC_PC_OFF = 8'h08;
  localparam logic [7:0] PTC_TC_OFF = 8'h0c;
  localparam logic [7:0] PTC_ISTAT_OFF = 8'h10;
  localparam logic [7:0] PTC_IMASK_OFF = 8'h14;

  // Process controls fields
  localparam int PTC_PC_TRC_EN_BIT = 0;
  localparam int PTC_PC_MODE_BIT = 1;
  localparam int PTC_PC_PEND_BIT = 10;
  localparam int PTC_PC_STATE_BIT = 13;
  localparam logic [31:0] PTC_PC_WMASK = 32'h0000_2003;

  // Trace controls fields: seven subtypes
  localparam int PTC_NSUB = 7;
  localparam int PTC_TC_MODE_LSB = 1;
  localparam int PTC_TC_EVT_LSB = 17;

  // Values after reset
  localparam logic [31:0] PTC_IP_RST = 32'h0000_0000;
  localparam logic [31:0] PTC_AC_RST = 32'h0000_0000;
  localparam logic PTC_MODE_RST = 1'b1;
  localparam logic [6:0] PTC_TC_RST = 7'h00;

  // Procedure entry types
  localparam logic [1:0] PTC_ENT_LOCAL = 2'h0;
  localparam logic [1:0] PTC_ENT_SUPER = 2'h2;

  // Interrupt status bits
  localparam int PTC_IRQ_W = 3;
  localparam int PTC_IRQ_TRACE = 0;
  localparam int PTC_IRQ_PRIV = 1;
  localparam int PTC_IRQ_SWITCH = 2;

  localparam logic [1:0] PTC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PTC_RESP_SLVERR = 2'h2;

  typedef enum logic {PTC_WR_IDLE, PTC_WR_RESP} ptc_wr_e;
endpackage : ptc_pkg

/* shared/ptc_trc_if.sv */
// Carrier between the control core and the trace fault unit.
// Assumes both ends share aclk.
`timescale 1ns/1ps
interface ptc_trc_if;
  logic [6:0] evt;
  logic [6:0] mode;
  logic [6:0] hit;
  logic trc_en;
  logic nontrace;
  logic fret;
  logic fault;
  logic pending;
  modport core (output evt, mode, trc_en, nontrace, fret, input hit, fault, pending);
  modport unit (input evt, mode, trc_en, nontrace, fret, output hit, fault, pending);
endinterface : ptc_trc_if

/* src/ptc_core.sv */
// Privilege and trace control: modes, stacks, system calls, trace faults.
// Assumes core strobes are one-cycle pulses on aclk; AXI4-Lite on aclk.
//
// Functional notes
// - Keep IP, arithmetic, process, trace control words
// - Supervisor entry from user switches mode, stack
// - Supervisor mode: supervisor stack, privileged ops allowed
// - User mode: local stack, privileged ops refused
// - Supervisor stack base from table bytes 12-15
// - Trace enable loads table byte 12 bit 0
// - Trace faults only when trace enable set; a pending trace fault is still raised on return with trace enable clear
// - Process controls bit 10 shows pending trace
// - Non-trace fault first, pending trace on return
// - Trace controls: mode and event per subtype
// - Enabled trace event raises a trace fault
// - System call: target pointer, local versus supervisor
// - Trace handlers located through trace table
// - State flag: program 0, interrupt 1
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module ptc_core (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // System calls
  input wire logic sys_call_valid,
  input wire logic [31:0] sys_call_entry,
  input wire logic [31:0] tbl_word12,
  input wire logic sys_return_user,
  // Privileged instructions
  input wire logic priv_attempt,
  input wire logic priv_modify_valid,
  input wire logic [31:0] priv_modify_data,
  // Core state
  input wire logic ip_update_valid,
  input wire logic [31:0] ip_update,
  input wire logic intr_enter,
  input wire logic intr_exit,
  // Trace and faults
  input wire logic [ptc_pkg::PTC_NSUB-1:0] trace_event,
  input wire logic nontrace_fault,
  input wire logic fault_return,
  // Outputs to the core
  output logic super_mode,
  output logic [31:0] sup_stack_base,
  output logic [31:0] call_target,
  output logic call_is_super,
  output logic call_done,
  output logic priv_fault,
  output logic priv_exec,
  output logic trace_fault,
  output logic trace_tbl_sel,
  output logic irq
);
  import ptc_pkg::*;

  ptc_trc_if trc ();

  ptc_trace u_trace (
    .aclk(aclk),
    .aresetn(aresetn),
    .trc(trc)
  );

  logic [31:0] ip_q;
  logic [31:0] ac_q;
  logic trc_en_q;
  logic super_q;
  logic state_q;
  logic [6:0] tc_mode_q;
  logic [6:0] tc_evt_q;
  logic [31:0] sstack_q;
  logic [31:0] target_q;
  logic is_super_q;
  logic done_q;
  logic pfault_q;
  logic pexec_q;
  logic tsel_q;
  logic [PTC_IRQ_W-1:0] stat_q;
  logic [PTC_IRQ_W-1:0] mask_q;
  logic irq_q;

  // Bus slave state
  ptc_wr_e wr_st_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic [7:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  logic wr_go;
  logic [31:0] bmask;
  logic wr_ip;
  logic wr_ac;
  logic wr_pc;
  logic wr_tc;
  logic wr_stat;
  logic wr_mask;
  logic wr_hit;
  logic [31:0] pc_word;
  logic [31:0] tc_word;
  logic [31:0] pc_new;
  logic [31:0] tc_new;
  logic to_super;
  logic mod_ok;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_bmask
      assign bmask[8*gi +: 8] = {8{wstrb_q[gi]}};
    end
  endgenerate

  assign wr_go = (wr_st_q == PTC_WR_IDLE) && !awready_q && !wready_q;
  assign wr_ip = wr_go && (waddr_q == PTC_IP_OFF);
  assign wr_ac = wr_go && (waddr_q == PTC_AC_OFF);
  assign wr_pc = wr_go && (waddr_q == PTC_PC_OFF);
  assign wr_tc = wr_go && (waddr_q == PTC_TC_OFF);
  assign wr_stat = wr_go && (waddr_q == PTC_ISTAT_OFF);
  assign wr_mask = wr_go && (waddr_q == PTC_IMASK_OFF);
  assign wr_hit = wr_ip || wr_ac || wr_pc || wr_tc || wr_stat || wr_mask;

  always_comb begin
    pc_word = '0;
    pc_word[PTC_PC_TRC_EN_BIT] = trc_en_q;
    pc_word[PTC_PC_MODE_BIT] = super_q;
    pc_word[PTC_PC_PEND_BIT] = trc.pending;
    pc_word[PTC_PC_STATE_BIT] = state_q;
    tc_word = '0;
    tc_word[PTC_TC_MODE_LSB +: PTC_NSUB] = tc_mode_q;
    tc_word[PTC_TC_EVT_LSB +: PTC_NSUB] = tc_evt_q;
  end

  // Reserved bits never land, even if software breaks the zero convention
  assign pc_new = ((pc_word & ~bmask) | (wdata_q & bmask)) & PTC_PC_WMASK;
  assign tc_new = (tc_word & ~bmask) | (wdata_q & bmask);

  assign to_super = sys_call_valid && !super_q
    && (sys_call_entry[1:0] == PTC_ENT_SUPER);
  assign mod_ok = priv_modify_valid && super_q;

  // Write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      waddr_q <= '0;
    end else if (s_axi_awvalid && awready_q) begin
      awready_q <= 1'b0;
      waddr_q <= {s_axi_awaddr[7:2], 2'h0};
    end else if (bvalid_q && s_axi_bready) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b1;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && wready_q) begin
      wready_q <= 1'b0;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (bvalid_q && s_axi_bready) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_st_q <= PTC_WR_IDLE;
      bvalid_q <= 1'b0;
      bresp_q <= PTC_RESP_OKAY;
    end else begin
      case (wr_st_q)
        PTC_WR_IDLE: begin
          if (wr_go) begin
            wr_st_q <= PTC_WR_RESP;
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? PTC_RESP_OKAY : PTC_RESP_SLVERR;
          end
        end
        PTC_WR_RESP: begin
          if (s_axi_bready) begin
            wr_st_q <= PTC_WR_IDLE;
            bvalid_q <= 1'b0;
          end
        end
        default: begin
          wr_st_q <= PTC_WR_IDLE;
          bvalid_q <= 1'b0;
        end
      endcase
    end
  end

  // Read channel: one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= PTC_RESP_OKAY;
      rdata_q <= '0;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= PTC_RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'h0})
        PTC_IP_OFF: rdata_q <= ip_q;
        PTC_AC_OFF: rdata_q <= ac_q;
        PTC_PC_OFF: rdata_q <= pc_word;
        PTC_TC_OFF: rdata_q <= tc_word;
        PTC_ISTAT_OFF: rdata_q <= {{(32-PTC_IRQ_W){1'b0}}, stat_q};
        PTC_IMASK_OFF: rdata_q <= {{(32-PTC_IRQ_W){1'b0}}, mask_q};
        default: begin
          rdata_q <= '0;
          rresp_q <= PTC_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // Instruction pointer and arithmetic controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ip_q <= PTC_IP_RST;
      ac_q <= PTC_AC_RST;
    end else begin
      if (ip_update_valid) begin
        ip_q <= ip_update;
      end else if (wr_ip) begin
        ip_q <= (ip_q & ~bmask) | (wdata_q & bmask);
      end
      if (wr_ac) begin
        ac_q <= (ac_q & ~bmask) | (wdata_q & bmask);
      end
    end
  end

  // Execution mode and trace enable; a supervisor switch outranks writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      super_q <= PTC_MODE_RST;
      trc_en_q <= 1'b0;
    end else if (to_super) begin
      super_q <= 1'b1;
      trc_en_q <= tbl_word12[0];
    end else if (mod_ok) begin
      super_q <= priv_modify_data[PTC_PC_MODE_BIT];
      trc_en_q <= priv_modify_data[PTC_PC_TRC_EN_BIT];
    end else if (sys_return_user) begin
      super_q <= 1'b0;
    end else if (wr_pc) begin
      super_q <= pc_new[PTC_PC_MODE_BIT];
      trc_en_q <= pc_new[PTC_PC_TRC_EN_BIT];
    end
  end

  // Program or interrupt state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= 1'b0;
    end else if (intr_enter) begin
      state_q <= 1'b1;
    end else if (intr_exit) begin
      state_q <= 1'b0;
    end else if (mod_ok) begin
      state_q <= priv_modify_data[PTC_PC_STATE_BIT];
    end else if (wr_pc) begin
      state_q <= pc_new[PTC_PC_STATE_BIT];
    end
  end

  // Trace controls; a detected event wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tc_mode_q <= PTC_TC_RST;
      tc_evt_q <= PTC_TC_RST;
    end else begin
      if (wr_tc) begin
        tc_mode_q <= tc_new[PTC_TC_MODE_LSB +: PTC_NSUB];
        tc_evt_q <= tc_new[PTC_TC_EVT_LSB +: PTC_NSUB] | trc.hit;
      end else begin
        tc_evt_q <= tc_evt_q | trc.hit;
      end
    end
  end

  // System calls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sstack_q <= '0;
      target_q <= '0;
      is_super_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= sys_call_valid;
      if (sys_call_valid) begin
        target_q <= {sys_call_entry[31:2], 2'h0};
        is_super_q <= sys_call_entry[1:0] == PTC_ENT_SUPER;
      end
      if (to_super) begin
        sstack_q <= {tbl_word12[31:2], 2'h0};
      end
    end
  end

  // Privileged instruction check
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pfault_q <= 1'b0;
      pexec_q <= 1'b0;
    end else begin
      pfault_q <= (priv_attempt || priv_modify_valid) && !super_q;
      pexec_q <= (priv_attempt || priv_modify_valid) && super_q;
    end
  end

  // Table select: trace table while a trace fault is served
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tsel_q <= 1'b0;
    end else if (trc.fault) begin
      tsel_q <= 1'b1;
    end else if (sys_call_valid || fault_return) begin
      tsel_q <= 1'b0;
    end
  end

  // Interrupt status, write one to clear; set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~(wr_stat ? wdata_q[PTC_IRQ_W-1:0] : '0))
        | {to_super, pfault_q, trc.fault};
      if (wr_mask) begin
        mask_q <= wdata_q[PTC_IRQ_W-1:0];
      end
      irq_q <= |(stat_q & mask_q);
    end
  end

  assign trc.evt = trace_event;
  assign trc.mode = tc_mode_q;
  assign trc.trc_en = trc_en_q;
  assign trc.nontrace = nontrace_fault;
  assign trc.fret = fault_return;

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign super_mode = super_q;
  assign sup_stack_base = sstack_q;
  assign call_target = target_q;
  assign call_is_super = is_super_q;
  assign call_done = done_q;
  assign priv_fault = pfault_q;
  assign priv_exec = pexec_q;
  assign trace_fault = trc.fault;
  assign trace_tbl_sel = tsel_q;
  assign irq = irq_q;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  super_switch_a: assert property (
    to_super |=> super_q && call_is_super && call_done)
    else $error("user supervisor call did not enter supervisor mode");

  stack_base_a: assert property (
    to_super |=> sup_stack_base == {$past(tbl_word12[31:2]), 2'h0})
    else $error("supervisor stack base not loaded");

  trace_load_a: assert property (
    to_super |=> pc_word[PTC_PC_TRC_EN_BIT] == $past(tbl_word12[0]))
    else $error("trace enable not loaded from table bit");

  user_refuse_a: assert property (
    priv_attempt && !super_q |=> priv_fault && !priv_exec)
    else $error("privileged op in user mode not refused");

  no_trace_a: assert property (
    !trc_en_q && !trc.pending |=> !trace_fault)
    else $error("trace fault with tracing disabled");

  trace_defer_a: assert property (
    (|(trace_event & tc_mode_q)) && trc_en_q && nontrace_fault
    |=> trc.pending && !trace_fault)
    else $error("trace fault not deferred behind other fault");

  pend_release_a: assert property (
    trc.pending && fault_return
    && !((|(trace_event & tc_mode_q)) && trc_en_q && nontrace_fault)
    |=> trace_fault)
    else $error("pending trace fault not raised on return");

  trace_raise_a: assert property (
    (|(trace_event & tc_mode_q)) && trc_en_q && !nontrace_fault
    |=> trace_fault ##1 tc_evt_q != '0)
    else $error("enabled trace event raised no fault");

  pend_bit_a: assert property (
    s_axi_arvalid && arready_q && s_axi_araddr == PTC_PC_OFF
    |=> s_axi_rvalid && s_axi_rdata[PTC_PC_PEND_BIT] == $past(trc.pending))
    else $error("pending flag not visible at bit 10");

  call_target_a: assert property (
    sys_call_valid |=> call_target == {$past(sys_call_entry[31:2]), 2'h0})
    else $error("system call target wrong");
endmodule : ptc_core

/* src/ptc_trace.sv */
// Trace fault unit: filters events and defers behind other faults.
// Assumes events and fault strobes are one-cycle pulses on aclk.
`timescale 1ns/1ps
module ptc_trace (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Core side
  ptc_trc_if.unit trc
);
  import ptc_pkg::*;

  logic [6:0] hit_now;
  logic [6:0] hit_q;
  logic fault_q;
  logic pend_q;

  assign hit_now = trc.evt & trc.mode & {PTC_NSUB{trc.trc_en}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit_q <= '0;
    end else begin
      hit_q <= hit_now;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_q <= 1'b0;
      pend_q <= 1'b0;
    end else if (|hit_now && trc.nontrace) begin
      fault_q <= 1'b0;
      pend_q <= 1'b1;
    end else if (|hit_now) begin
      fault_q <= 1'b1;
    end else if (trc.fret && pend_q) begin
      fault_q <= 1'b1;
      pend_q <= 1'b0;
    end else begin
      fault_q <= 1'b0;
    end
  end

  assign trc.hit = hit_q;
  assign trc.fault = fault_q;
  assign trc.pending = pend_q;
endmodule : ptc_trace

/* verification/tb_top.sv */
// Self-checking bench for the privilege and trace control core.
// Assumes ptc_pkg and ptc_core are compiled first; the bench drives every port.
`timescale 1ns/1ps
module tb_top;
  import ptc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic sys_call_valid = 1'b0, sys_return_user = 1'b0, priv_attempt = 1'b0;
  logic priv_modify_valid = 1'b0, ip_update_valid = 1'b0, intr_enter = 1'b0;
  logic intr_exit = 1'b0, nontrace_fault = 1'b0, fault_return = 1'b0;
  logic [31:0] sys_call_entry = 32'h0, tbl_word12 = 32'h0, priv_modify_data = 32'h0;
  logic [31:0] ip_update = 32'h0;
  logic [PTC_NSUB-1:0] trace_event = 7'h00;
  logic super_mode, call_is_super, call_done, priv_fault, priv_exec;
  logic trace_fault, trace_tbl_sel, irq;
  logic [31:0] sup_stack_base, call_target;
  int fails = 0;
  int n_compared = 0;
  integer seed = 32'hc6e7bee7;
  // Model of the control state, kept from the rules alone
  int m_ten = 0, m_mode = 1, m_pend = 0, m_state = 0, m_st = 0;
  logic [31:0] rd, v, w;
  logic [1:0] rs;
  int i;

  always #10 aclk = ~aclk;

  ptc_core uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sys_call_valid, .sys_call_entry, .tbl_word12, .sys_return_user,
    .priv_attempt, .priv_modify_valid, .priv_modify_data, .ip_update_valid, .ip_update,
    .intr_enter, .intr_exit, .trace_event, .nontrace_fault, .fault_return, .super_mode,
    .sup_stack_base, .call_target, .call_is_super, .call_done, .priv_fault, .priv_exec,
    .trace_fault, .trace_tbl_sel, .irq);

  function automatic logic [31:0] m_proc();
    return 32'(m_ten) | 32'(m_mode << 1) | 32'(m_pend << 10) | 32'(m_state << 13);
  endfunction : m_proc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk1

  // Drops every core strobe at the edge that samples it, then lets flops settle
  task automatic tick();
    @(posedge aclk);
    sys_call_valid <= 1'b0;
    sys_return_user <= 1'b0;
    priv_attempt <= 1'b0;
    priv_modify_valid <= 1'b0;
    ip_update_valid <= 1'b0;
    intr_enter <= 1'b0;
    intr_exit <= 1'b0;
    trace_event <= 7'h00;
    nontrace_fault <= 1'b0;
    fault_return <= 1'b0;
    #1;
  endtask : tick

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (s_axi_bvalid !== 1'b1) begin
      fails++;
      $display("BAD t=%0t bvalid=%h exp=%h", $time, s_axi_bvalid, 1'b1);
    end
  endtask : axw

  task automatic ard(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (s_axi_rvalid !== 1'b1) begin
      fails++;
      $display("BAD t=%0t rvalid=%h exp=%h", $time, s_axi_rvalid, 1'b1);
    end
  endtask : ard

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axw(a, d, rs);
    chk({30'h0, rs}, {30'h0, PTC_RESP_OKAY});
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    ard(a, rd, rs);
    chk(rd, exp);
    chk({30'h0, rs}, {30'h0, PTC_RESP_OKAY});
  endtask : rchk

  task automatic wait_irq();
    repeat (2) @(posedge aclk);
    #1;
  endtask : wait_irq

  task automatic summarize();
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    summarize();
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    tick();
    chk1(super_mode, 1'b1);
    rchk(PTC_IP_OFF, PTC_IP_RST);
    rchk(PTC_AC_OFF, PTC_AC_RST);
    rchk(PTC_PC_OFF, m_proc());
    rchk(PTC_TC_OFF, 32'h0);
    rchk(PTC_ISTAT_OFF, 32'h0);
    rchk(PTC_IMASK_OFF, 32'h0);
    // Unmapped word answers an error and reads zero
    ard(8'h18, rd, rs);
    chk(rd, 32'h0);
    chk({30'h0, rs}, {30'h0, PTC_RESP_SLVERR});
    axw(8'h18, 32'hffff_ffff, rs);
    chk({30'h0, rs}, {30'h0, PTC_RESP_SLVERR});
    v = $random(seed);
    wr(PTC_AC_OFF, v);
    rchk(PTC_AC_OFF, v);
    v = $random(seed);
    @(posedge aclk);
    ip_update <= v;
    ip_update_valid <= 1'b1;
    tick();
    rchk(PTC_IP_OFF, v);
    // Byte strobes merge into the word
    w = $random(seed);
    @(posedge aclk);
    s_axi_wstrb <= 4'h3;
    wr(PTC_IP_OFF, w);
    rchk(PTC_IP_OFF, {v[31:16], w[15:0]});
    @(posedge aclk);
    s_axi_wstrb <= 4'hf;
    $display("test registers done at %0t", $time);

    @(posedge aclk);
    priv_attempt <= 1'b1;
    tick();
    chk1(priv_exec, 1'b1);
    @(posedge aclk);
    sys_return_user <= 1'b1;
    tick();
    m_mode = 0;
    chk1(super_mode, 1'b0);
    @(posedge aclk);
    priv_attempt <= 1'b1;
    tick();
    chk1(priv_fault, 1'b1);
    chk1(priv_exec, 1'b0);
    @(posedge aclk);
    priv_modify_valid <= 1'b1;
    priv_modify_data <= 32'h1;
    tick();
    chk1(priv_fault, 1'b1);
    m_st = 2;
    rchk(PTC_PC_OFF, m_proc());
    v = $random(seed);
    @(posedge aclk);
    sys_call_valid <= 1'b1;
    sys_call_entry <= {v[31:2], PTC_ENT_LOCAL};
    tbl_word12 <= $random(seed);
    tick();
    chk1(call_done, 1'b1);
    chk1(call_is_super, 1'b0);
    chk1(super_mode, 1'b0);
    chk(call_target, {v[31:2], 2'h0});
    for (i = 0; i < 2; i++) begin
      v = $random(seed);
      w = $random(seed);
      w[0] = (i == 1);
      @(posedge aclk);
      sys_call_valid <= 1'b1;
      sys_call_entry <= {v[31:2], PTC_ENT_SUPER};
      tbl_word12 <= w;
      tick();
      m_mode = 1;
      m_ten = i;
      m_st = m_st | 4;
      chk1(super_mode, 1'b1);
      chk1(call_is_super, 1'b1);
      chk(sup_stack_base, {w[31:2], 2'h0});
      rchk(PTC_PC_OFF, m_proc());
      if (i == 0) begin
        @(posedge aclk);
        sys_return_user <= 1'b1;
        tick();
        m_mode = 0;
      end
    end
    // Reserved bits are written as zero
    @(posedge aclk);
    priv_modify_valid <= 1'b1;
    priv_modify_data <= 32'h2002;
    tick();
    chk1(priv_exec, 1'b1);
    m_state = 1;
    m_ten = 0;
    rchk(PTC_PC_OFF, m_proc());
    @(posedge aclk);
    intr_exit <= 1'b1;
    tick();
    m_state = 0;
    rchk(PTC_PC_OFF, m_proc());
    @(posedge aclk);
    intr_enter <= 1'b1;
    tick();
    m_state = 1;
    rchk(PTC_PC_OFF, m_proc());
    rchk(PTC_ISTAT_OFF, 32'(m_st));
    $display("test privilege done at %0t", $time);

    wr(PTC_PC_OFF, 32'h3);
    m_ten = 1;
    m_state = 0;
    for (i = 0; i < PTC_NSUB; i++) begin
      wr(PTC_TC_OFF, 32'h1 << (i + PTC_TC_MODE_LSB));
      @(posedge aclk);
      trace_event <= 7'h1 << ((i + 1) % PTC_NSUB);
      tick();
      chk1(trace_fault, 1'b0);
      @(posedge aclk);
      trace_event <= 7'h1 << i;
      tick();
      chk1(trace_fault, 1'b1);
      ard(PTC_TC_OFF, rd, rs);
      chk(rd & (32'h1 << (PTC_TC_EVT_LSB + i)), 32'h1 << (17 + i));
    end
    m_st = m_st | 1;
    wr(PTC_PC_OFF, 32'h2);
    m_ten = 0;
    wr(PTC_TC_OFF, 32'hfe);
    @(posedge aclk);
    trace_event <= 7'h7f;
    tick();
    chk1(trace_fault, 1'b0);
    $display("test trace done at %0t", $time);

    wr(PTC_PC_OFF, 32'h3);
    m_ten = 1;
    @(posedge aclk);
    trace_event <= 7'h02;
    nontrace_fault <= 1'b1;
    tick();
    chk1(trace_fault, 1'b0);
    m_pend = 1;
    rchk(PTC_PC_OFF, m_proc());
    @(posedge aclk);
    fault_return <= 1'b1;
    tick();
    chk1(trace_fault, 1'b1);
    m_pend = 0;
    @(posedge aclk);
    #1;
    chk1(trace_tbl_sel, 1'b1);
    rchk(PTC_PC_OFF, m_proc());
    $display("test deferred done at %0t", $time);

    rchk(PTC_ISTAT_OFF, 32'(m_st));
    chk1(irq, 1'b0);
    wr(PTC_IMASK_OFF, 32'h4);
    wait_irq();
    chk1(irq, 1'b1);
    wr(PTC_ISTAT_OFF, 32'h4);
    m_st = m_st & 3;
    wait_irq();
    chk1(irq, 1'b0);
    rchk(PTC_ISTAT_OFF, 32'(m_st));
    wr(PTC_IMASK_OFF, 32'h7);
    wait_irq();
    chk1(irq, 1'b1);
    wr(PTC_ISTAT_OFF, 32'h3);
    wait_irq();
    chk1(irq, 1'b0);
    rchk(PTC_ISTAT_OFF, 32'h0);
    $display("test interrupt done at %0t", $time);
    summarize();
  end
endmodule : tb_top
